// ---- rtl/gxp_expander.sv ----
// i2c target port expander with apb interrupt status and mask
//
// The implementer's own choices: the register addresses and the APB slave port.
module gxp_expander
	import gxp_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        scl_i,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	input  wire logic        addr_strap_bit0,
	input  wire logic        addr_strap_bit1,
	input  wire logic        addr_strap_bit2,
	input  wire logic [7:0]  port_pin_i,
	output logic      [7:0]  port_pin_o,
	output logic      [7:0]  port_pin_oe,
	output logic             int_n_o,
	output logic             int_n_oe,
	output logic             irq,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr
);
	logic [12:0] raw_s;
	logic [7:0]  pins_s;
	logic [2:0]  strap_s;
	logic        scl_s;
	logic        sda_s;
	logic        scl_f;
	logic        sda_f;
	logic        scl_p_q;
	logic        sda_p_q;
	logic        scl_rise;
	logic        scl_fall;
	logic        bus_start;
	logic        bus_stop;

	logic [4:0]  init_cnt_q;
	logic        init_done_q;
	logic [2:0]  addr_lo_q;

	logic [7:0]  in_q;
	logic [7:0]  out_q;
	logic [7:0]  pol_q;
	logic [7:0]  dir_q;
	logic [1:0]  ptr_q;

	gxp_state_t  state_q;
	logic [3:0]  bit_cnt_q;
	logic [7:0]  rx_q;
	logic [7:0]  tx_q;
	logic        rw_q;
	logic        mack_q;
	logic        sda_oe_q;
	logic        od_low_q;

	logic [7:0]  diff;
	logic        change;
	logic        change_q;
	logic        ev_write;
	logic        ev_inread;
	logic [EV_W-1:0] events;
	logic [EV_W-1:0] stat_q;
	logic [EV_W-1:0] mask_q;

	logic        apb_acc;
	logic        apb_wr;
	logic        cap_in;
	logic        load_tx;
	logic [7:0]  rd_val;

	// every pin-side level passes two flops before anything looks at it
	assign raw_s = {scl_i, sda_i, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0,
		port_pin_i};

	gxp_sync #(
		.W (13)
	) u_sync (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.d       (raw_s),
		.q       ({scl_s, sda_s, strap_s, pins_s})
	);

	gxp_filt u_filt_scl (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.d       (scl_s),
		.q       (scl_f)
	);

	gxp_filt u_filt_sda (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.d       (sda_s),
		.q       (sda_f)
	);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_f;
			sda_p_q <= sda_f;
		end
	end

	// only edges count, never their spacing, so a stalled clock is harmless
	assign scl_rise  = init_done_q & scl_f & ~scl_p_q;
	assign scl_fall  = init_done_q & ~scl_f & scl_p_q;
	assign bus_start = init_done_q & scl_f & scl_p_q & ~sda_f & sda_p_q;
	assign bus_stop  = init_done_q & scl_f & scl_p_q & sda_f & ~sda_p_q;

	// hold everything quiet until the sync and filter pipes have settled
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			init_cnt_q  <= '0;
			init_done_q <= 1'b0;
		end else if (!init_done_q) begin
			init_cnt_q  <= init_cnt_q + 5'd1;
			init_done_q <= (init_cnt_q == 5'(INIT_CYC - 1));
		end
	end

	// straps caught once, after release of reset
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			addr_lo_q <= '0;
		end else if (!init_done_q) begin
			addr_lo_q <= strap_s;
		end
	end

	// readback value of the selected register
	always_comb begin
		case (ptr_q)
			PTR_INPUT:  rd_val = pins_s ^ pol_q;
			PTR_OUTPUT: rd_val = out_q;
			PTR_POLAR:  rd_val = pol_q;
			PTR_DIR:    rd_val = dir_q;
			default:    rd_val = 8'h00;
		endcase
	end

	assign load_tx = ((state_q == ST_AACK) & rw_q & scl_fall)
		| ((state_q == ST_RACK) & scl_fall & ~mack_q);
	assign cap_in  = load_tx & (ptr_q == PTR_INPUT);

	// serial target state machine
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_q   <= ST_IDLE;
			bit_cnt_q <= '0;
			rx_q      <= '0;
			rw_q      <= 1'b0;
			mack_q    <= 1'b1;
		end else if (bus_stop) begin
			state_q <= ST_IDLE;
		end else if (bus_start) begin
			state_q   <= ST_ADDR;
			bit_cnt_q <= '0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					bit_cnt_q <= '0;
				end
				ST_ADDR, ST_CMD, ST_WDAT: begin
					if (scl_rise) begin
						rx_q      <= {rx_q[6:0], sda_f};
						bit_cnt_q <= bit_cnt_q + 4'd1;
					end else if (scl_fall && bit_cnt_q == 4'd8) begin
						bit_cnt_q <= '0;
						if (state_q == ST_ADDR) begin
							rw_q    <= rx_q[0];
							state_q <= (rx_q[7:1] == {ADDR_FIXED[6:3], addr_lo_q})
								? ST_AACK : ST_IDLE;
						end else begin
							state_q <= (state_q == ST_CMD) ? ST_CACK : ST_WACK;
						end
					end
				end
				ST_AACK: begin
					if (scl_fall) begin
						state_q <= rw_q ? ST_RDAT : ST_CMD;
					end
				end
				ST_CACK, ST_WACK: begin
					// a data byte goes to the same register again
					if (scl_fall) begin
						state_q <= ST_WDAT;
					end
				end
				ST_RDAT: begin
					if (scl_rise) begin
						bit_cnt_q <= bit_cnt_q + 4'd1;
					end else if (scl_fall && bit_cnt_q == 4'd8) begin
						bit_cnt_q <= '0;
						state_q   <= ST_RACK;
					end
				end
				ST_RACK: begin
					if (scl_rise) begin
						mack_q <= sda_f;
					end else if (scl_fall) begin
						state_q <= mack_q ? ST_IDLE : ST_RDAT;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// transmit shifter and open-drain data driver
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			tx_q     <= '0;
			sda_oe_q <= 1'b0;
		end else if (bus_stop || bus_start) begin
			sda_oe_q <= 1'b0;
		end else if (load_tx) begin
			tx_q     <= rd_val;
			sda_oe_q <= ~rd_val[7];
		end else if (scl_fall) begin
			case (state_q)
				ST_ADDR: begin
					sda_oe_q <= (bit_cnt_q == 4'd8)
						&& (rx_q[7:1] == {ADDR_FIXED[6:3], addr_lo_q});
				end
				ST_CMD, ST_WDAT: begin
					sda_oe_q <= (bit_cnt_q == 4'd8);
				end
				ST_RDAT: begin
					if (bit_cnt_q == 4'd8) begin
						sda_oe_q <= 1'b0;
					end else begin
						tx_q     <= {tx_q[6:0], 1'b0};
						sda_oe_q <= ~tx_q[6];
					end
				end
				default: begin
					sda_oe_q <= 1'b0;
				end
			endcase
		end
	end

	assign ev_write = (state_q == ST_WDAT) & scl_fall & (bit_cnt_q == 4'd8);

	// pointer byte latch; values above three keep their low two bits
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ptr_q <= PTR_INPUT;
		end else if (state_q == ST_CMD && scl_fall && bit_cnt_q == 4'd8) begin
			ptr_q <= rx_q[1:0];
		end
	end

	// host-written settings
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			out_q <= RST_OUTPUT;
			pol_q <= RST_POLAR;
			dir_q <= RST_DIR;
		end else if (ev_write) begin
			case (ptr_q)
				PTR_OUTPUT: out_q <= rx_q;
				PTR_POLAR:  pol_q <= rx_q;
				PTR_DIR:    dir_q <= rx_q;
				default:    ; // input register ignores writes
			endcase
		end
	end

	// input register: raw levels; polarity applied only on readout
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			in_q <= '0;
		end else if (!init_done_q || cap_in) begin
			in_q <= pins_s;
		end
	end

	// pins that are outputs never flag a change
	assign diff   = (pins_s ^ in_q) & dir_q;
	assign change = |diff;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			change_q <= 1'b0;
		end else begin
			change_q <= change & init_done_q;
		end
	end

	// pin drivers stay off until initialisation ends
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			port_pin_o  <= RST_OUTPUT;
			port_pin_oe <= '0;
		end else begin
			port_pin_o  <= out_q;
			port_pin_oe <= init_done_q ? ~dir_q : 8'h00;
		end
	end

	// open-drain interrupt and data: the output value is always low
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			od_low_q <= 1'b0;
			int_n_oe <= 1'b0;
		end else begin
			od_low_q <= 1'b0;
			int_n_oe <= change & init_done_q;
		end
	end

	assign int_n_o = od_low_q;
	assign sda_o   = od_low_q;
	assign sda_oe  = sda_oe_q;

	assign ev_inread = cap_in;
	assign events    = {ev_inread, ev_write, change & ~change_q};

	// apb: one wait state, answer registered
	assign apb_acc = psel & penable & ~pready;
	assign apb_wr  = psel & penable & pready & pwrite;

	// sticky status, write one to clear; a fresh event beats the clear
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			stat_q <= '0;
		end else begin
			for (int i = 0; i < EV_W; i++) begin
				if (events[i]) begin
					stat_q[i] <= 1'b1;
				end else if (apb_wr && paddr == OFS_IRQ_STAT && pwdata[i]) begin
					stat_q[i] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			mask_q <= RST_MASK;
		end else if (apb_wr && paddr == OFS_IRQ_MASK) begin
			mask_q <= pwdata[EV_W-1:0];
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(stat_q & mask_q);
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= apb_acc;
			pslverr <= 1'b0;
			prdata  <= '0;
			if (apb_acc) begin
				case (paddr)
					OFS_IRQ_STAT: prdata <= {29'h0, stat_q};
					OFS_IRQ_MASK: prdata <= {29'h0, mask_q};
					OFS_PORT_ST:  if (!pwrite) begin
						prdata <= {dir_q, pol_q, out_q, in_q};
					end else begin
						pslverr <= 1'b1;
					end
					default:      pslverr <= 1'b1;
				endcase
			end
		end
	end
endmodule

// ---- rtl/gxp_filt.sv ----
// glitch filter: output follows input once it has been stable long enough
module gxp_filt
	import gxp_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic nrst,
	input  wire logic d,
	output logic      q
);
	logic [4:0] cnt_q;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cnt_q <= '0;
			q     <= 1'b1;
		end else if (d == q) begin
			cnt_q <= '0;
		end else if (cnt_q == 5'(GLITCH_CYC - 1)) begin
			cnt_q <= '0;
			q     <= d;
		end else begin
			cnt_q <= cnt_q + 5'd1;
		end
	end
endmodule

// ---- rtl/gxp_pkg.sv ----
// constants for the eight-bit i2c port expander
// Operation
// - eight direction bits, written by the bus host, make each pin input or output.
// - a set polarity bit inverts that pin in the input value register readout.
// - input register keeps sampled pin levels; output register keeps levels to drive.
// - every register, including direction, output and polarity, is readable over i2c.
// - interrupt asserts while any input pin differs from its stored input bit.
// - interrupt is active low open drain: pulls low when asserted, else undriven.
// - reset loads every register default and puts the bus state machine idle.
// - after reset all eight pins are inputs with drivers off.
// - three strap pins set the low three bits of the fixed target address.
// - bus works from static clock up to 400 kHz, no minimum-rate timing.
// - short glitches on serial clock and data are filtered before protocol logic.
// - no glitch at power-up; outputs hold reset state until initialisation completes.
// - pointer byte after address selects 0 input, 1 output, 2 polarity, 3 direction.
// - interrupt clears when input returns to old level or input register is read.
// - direction one makes a high-impedance input; zero drives the output value bit.
// - pointer never auto-increments; reads repeat the selected register until changed.
package gxp_pkg;
	localparam int          CLK_NS       = 4;
	// short enough that an ack turns round inside a fast bus clock low phase
	localparam int          GLITCH_NS    = 20;
	localparam int          GLITCH_CYC   = (GLITCH_NS + CLK_NS - 1) / CLK_NS;
	localparam int          INIT_CYC     = GLITCH_CYC + 4;
	localparam logic [6:0]  ADDR_FIXED   = 7'h58; // upper four bits arbitrary
	localparam logic [1:0]  PTR_INPUT    = 2'h0;
	localparam logic [1:0]  PTR_OUTPUT   = 2'h1;
	localparam logic [1:0]  PTR_POLAR    = 2'h2;
	localparam logic [1:0]  PTR_DIR      = 2'h3;
	localparam logic [7:0]  RST_OUTPUT   = 8'hff;
	localparam logic [7:0]  RST_POLAR    = 8'h00;
	localparam logic [7:0]  RST_DIR      = 8'hff;
	localparam logic [11:0] OFS_IRQ_STAT = 12'h000;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h004;
	localparam logic [11:0] OFS_PORT_ST  = 12'h008;
	localparam int          EV_CHANGE    = 0;
	localparam int          EV_WRITE     = 1;
	localparam int          EV_INREAD    = 2;
	localparam int          EV_W         = 3;
	localparam logic [2:0]  RST_MASK     = 3'h0;

	typedef enum logic [8:0] {
		ST_IDLE = 9'h001,
		ST_ADDR = 9'h002,
		ST_AACK = 9'h004,
		ST_CMD  = 9'h008,
		ST_CACK = 9'h010,
		ST_WDAT = 9'h020,
		ST_WACK = 9'h040,
		ST_RDAT = 9'h080,
		ST_RACK = 9'h100
	} gxp_state_t;
endpackage

// ---- rtl/gxp_sync.sv ----
// two-stage synchroniser for a bundle of asynchronous levels
module gxp_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_q;

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end
endmodule

// ---- testbench/gxp_expander_sva.sv ----
// concurrent checks on the expander's apb, open-drain and port pin outputs
module gxp_expander_sva
	import gxp_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        int_n_o,
	input wire logic        int_n_oe,
	input wire logic        sda_o,
	input wire logic        sda_oe,
	input wire logic        irq,
	input wire logic [7:0]  port_pin_o,
	input wire logic [7:0]  port_pin_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	wire logic acc = psel && penable && !pready;
	chk_apb_wait: assert property (acc |=> pready)
		else $error("apb answer late");
	chk_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held");
	chk_err_unmap: assert property (acc && paddr > 12'h008 |=> pslverr)
		else $error("unmapped access accepted");
	chk_err_ro: assert property (acc && pwrite && paddr == OFS_PORT_ST |=> pslverr)
		else $error("read-only write accepted");
	chk_err_only: assert property (pslverr |-> pready)
		else $error("error without ready");
	chk_int_drain: assert property (int_n_oe |-> !int_n_o)
		else $error("interrupt driven high");
	chk_sda_drain: assert property (sda_oe |-> !sda_o)
		else $error("sda driven high");
	chk_init_quiet: assert property ($rose(nrst) |->
		(port_pin_oe == 8'h00 && !int_n_oe && port_pin_o == 8'hff) [*8])
		else $error("pins moved during init");
	cover property ($rose(int_n_oe));
	cover property ($rose(irq));
	cover property (pslverr);
endmodule

bind gxp_expander gxp_expander_sva u_sva (
	.clk_sys(clk_sys), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pready(pready), .pslverr(pslverr), .int_n_o(int_n_o),
	.int_n_oe(int_n_oe), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq),
	.port_pin_o(port_pin_o), .port_pin_oe(port_pin_oe)
);

// ---- testbench/gxp_i2c_host.sv ----
// i2c bus host model for the expander's serial side
module gxp_i2c_host (
	output logic      scl,
	output logic      sda_m,
	input  wire logic sda
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam realtime Q = 31.25;
	// bus clock stands high between frames
	initial begin
		scl = 1'b1;
		sda_m = 1'b1;
	end
	task automatic st();
		sda_m = 1'b1;
		#Q scl = 1'b1;
		#Q sda_m = 1'b0;
		#Q scl = 1'b0;
	endtask
	// nine bits msb first; a one releases sda so the target may answer
	task automatic xb(input logic [8:0] t, output logic [8:0] r);
		for (int i = 8; i >= 0; i--) begin
			#Q sda_m = t[i];
			#Q scl = 1'b1;
			#Q r[i] = sda;
			#Q scl = 1'b0;
		end
	endtask
	// long static low phase with a clock spike too short to count
	task automatic gl();
		#1000 scl = 1'b1;
		#8 scl = 1'b0;
		#1000;
	endtask
	task automatic sp();
		#Q sda_m = 1'b0;
		#Q scl = 1'b1;
		#Q sda_m = 1'b1;
		#Q;
	endtask
endmodule

// ---- testbench/tb_top.sv ----
// self-checking bench for the i2c port expander
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import gxp_pkg::*;
	logic        clk_sys, nrst, psel, penable, pwrite, pready, pslverr, irq;
	logic        sda_o, sda_oe, int_n_o, int_n_oe, scl, sda_m;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:0]  port_pin_o, port_pin_oe, ext, v, pe;
	logic [7:0]  rg [4];
	logic [2:0]  strap;
	logic [8:0]  r;
	logic [33:0] exp_q [$];
	int          seed, fail_count, samples_checked, cyc;
	// open-drain lines with pull-ups; outputs win over the far-side drive
	wire logic       sda = sda_m && !(sda_oe && !sda_o);
	wire logic       int_l = !(int_n_oe && !int_n_o);
	wire logic [7:0] pin = (port_pin_oe & port_pin_o) | (~port_pin_oe & ext);
	wire logic [6:0] adr = {ADDR_FIXED[6:3], strap};
	gxp_i2c_host u_host (.scl(scl), .sda_m(sda_m), .sda(sda));
	gxp_expander u_dut (
		.clk_sys(clk_sys), .nrst(nrst), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe(sda_oe), .addr_strap_bit0(strap[0]), .addr_strap_bit1(strap[1]),
		.addr_strap_bit2(strap[2]), .port_pin_i(pin), .port_pin_o(port_pin_o),
		.port_pin_oe(port_pin_oe), .int_n_o(int_n_o), .int_n_oe(int_n_oe), .irq(irq),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr)
	);
	always #2 clk_sys = !clk_sys;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, e,
		input logic er);
		exp_q.push_back({w, er, e});
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		@(posedge clk_sys);
		while (pready !== 1'b1) @(posedge clk_sys);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// result watcher: each answer is matched against the oldest note
	always @(posedge clk_sys) begin
		if (psel && penable && pready === 1'b1) begin
			chk(32'(pslverr), 32'(exp_q[0][32]));
			if (!exp_q[0][33])
				chk(prdata, exp_q[0][31:0]);
			void'(exp_q.pop_front());
		end
	end
	task automatic iw(input logic [7:0] p, input logic [7:0] d);
		u_host.st();
		u_host.xb({adr, 2'b01}, r);
		u_host.xb({p, 1'b1}, r);
		u_host.xb({d, 1'b1}, r);
		chk(32'(r[0]), 0);
		u_host.sp();
	endtask
	task automatic ir(input logic [7:0] e);
		u_host.st();
		u_host.xb({adr, 2'b11}, r);
		chk(32'(r[0]), 0);
		u_host.xb(9'h1fe, r);
		chk(32'(r[8:1]), 32'(e));
		u_host.xb(9'h1ff, r);
		chk(32'(r[8:1]), 32'(e));
		u_host.sp();
	endtask
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 40000) begin
			fail_count++;
			report_and_stop();
		end
	end
	initial begin
		{clk_sys, nrst, psel, penable, pwrite, paddr, pwdata} = '0;
		strap = 3'h5;
		ext = 8'h00;
		seed = 59739;
		repeat (5) @(posedge clk_sys);
		nrst <= 1'b1;
		chk(32'(port_pin_oe), 0);
		apb(0, OFS_PORT_ST, 0, 32'hff00_ff00, 0);
		#1000;
		$display("test reset done");
		for (int p = 1; p < 4; p++) begin
			v = 8'($random(seed));
			if (p == 3)
				v[0] = 1'b1;
			rg[p] = v;
			iw(8'(p), v);
			ir(v);
		end
		chk(32'(port_pin_oe), {24'h0, ~rg[3]});
		chk(32'(port_pin_o), 32'(rg[1]));
		ext = 8'($random(seed));
		pe = (~rg[3] & rg[1]) | (rg[3] & ext);
		iw(0, 8'h5a);
		ir(pe ^ rg[2]);
		chk(32'(int_l), 1);
		chk(32'(port_pin_o), 32'(rg[1]));
		$display("test registers done");
		apb(1, OFS_IRQ_STAT, 32'h0000_0007, 0, 0);
		apb(1, OFS_IRQ_MASK, 32'h0000_0001, 0, 0);
		ext[0] <= !ext[0];
		#300;
		chk(32'(int_l), 0);
		chk(32'(irq), 1);
		apb(0, OFS_IRQ_STAT, 0, 32'h0000_0001, 0);
		apb(1, OFS_IRQ_STAT, 32'h0000_0001, 0, 0);
		apb(0, OFS_IRQ_STAT, 0, 0, 0);
		chk(32'(irq), 0);
		ext[0] <= !ext[0];
		#300;
		chk(32'(int_l), 1);
		$display("test interrupt done");
		u_host.st();
		u_host.xb({adr ^ 7'h01, 2'b01}, r);
		chk(32'(r[0]), 1);
		u_host.sp();
		u_host.st();
		u_host.xb({adr, 2'b11}, r);
		u_host.gl();
		u_host.xb(9'h1ff, r);
		chk(32'(r[8:1]), 32'(pe ^ rg[2]));
		u_host.sp();
		$display("test filter done");
		apb(0, 12'h00c, 0, 0, 1);
		apb(1, OFS_PORT_ST, 32'h0000_00ff, 0, 1);
		repeat (3) @(posedge clk_sys);
		$display("test refusals done");
		report_and_stop();
	end
endmodule
